// File: hdl/hso_pkg.sv
// Constants and carrier types for the hot-plug slot serial output control block.
// Assumes a single core clock; pin-side signals are synchronised before use, except the fault override and NAND tree paths.
package hso_pkg;
   // Chain geometry: 8 bits per slot, two slots per device
   localparam int HSO_SLOT_W = 8;
   localparam int HSO_SR_W = 16;
   localparam int HSO_NSLOT = 2;
   // Slot A byte arrives last, so it rests in the upper byte
   localparam int HSO_A_BASE = 8;
   localparam int HSO_B_BASE = 0;
   // Bit positions inside a slot control byte
   localparam int HSO_B_PWR = 0;
   localparam int HSO_B_CLK = 1;
   localparam int HSO_B_BUS = 2;
   localparam int HSO_B_RST = 3;
   localparam int HSO_B_PLED = 4;
   localparam int HSO_B_ALED = 5;
   // NAND tree length
   localparam int HSO_NAND_N = 33;
   // Synchroniser lane indices
   localparam int HSO_SY_SHIFT = 0;
   localparam int HSO_SY_CTL = 1;
   localparam int HSO_SY_RLC = 2;
   localparam int HSO_SY_DIN = 3;
   localparam int HSO_SY_PG = 4;
   localparam int HSO_SY_TEST = 5;
   localparam int HSO_SY_MHI = 6;
   localparam int HSO_SY_MLO = 7;
   localparam int HSO_SY_FLT = 8;
   localparam int HSO_SY_CIN = 10;
   localparam int HSO_SY_W = 11;
   // Register map (byte addresses)
   localparam logic [4:0] HSO_REG_STATE = 5'h00;
   localparam logic [4:0] HSO_REG_IRQ_STAT = 5'h04;
   localparam logic [4:0] HSO_REG_IRQ_MASK = 5'h08;
   localparam logic [4:0] HSO_REG_SHIFT = 5'h0c;
   // Interrupt status bits
   localparam int HSO_EV_CTL = 0;
   localparam int HSO_EV_RLC = 1;
   localparam int HSO_EV_FLTA = 2;
   localparam int HSO_EV_FLTB = 3;
   localparam int HSO_EV_PG = 4;
   localparam int HSO_EV_W = 5;
   localparam logic [HSO_EV_W-1:0] HSO_MASK_RST = 5'h00;
   // STATE register field positions
   localparam int HSO_ST_MODE = 0;
   localparam int HSO_ST_RTT = 5;
   localparam int HSO_ST_MLO = 6;
   localparam int HSO_ST_MHI = 7;
   localparam int HSO_ST_SLA = 8;
   localparam int HSO_ST_SLB = 16;

   typedef enum logic [4:0] {
      HSO_WAIT = 5'h01,
      HSO_OPER = 5'h02,
      HSO_NAND = 5'h04,
      HSO_TRI = 5'h08,
      HSO_RSVD = 5'h10
   } hso_mode_e;

   // Pin levels for one slot
   typedef struct packed {
      logic pwr_en;
      logic clk_en_n;
      logic bus_en_n;
      logic reset_n;
      logic pled;
      logic aled;
   } hso_slot_s;

   localparam hso_slot_s HSO_SLOT_INIT = '{pwr_en: 1'b0, clk_en_n: 1'b1, bus_en_n: 1'b1,
                                           reset_n: 1'b0, pled: 1'b1, aled: 1'b1};
endpackage

// File: hdl/hso_out_ctrl.sv
// Serial-to-parallel slot output control for two hot-plug slots, with register slave.
// Assumes shift and latch clocks come from a remote controller and are far slower than
// i_core_clk (at least four core cycles per level), so they are sampled, not used as clocks.
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module hso_out_ctrl (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_out_shift_clock,
   input wire logic i_control_latch_clock,
   input wire logic i_slot_reset_latch_clock,
   input wire logic i_out_chain_data_in,
   input wire logic i_power_good,
   input wire logic i_test,
   input wire logic [1:0] i_pwr_fault_n,
   input wire logic [1:0] i_aux_fault_n,
   input wire logic i_in_chain_data_in,
   input wire logic [hso_pkg::HSO_NAND_N-1:0] i_nand_tree_pins,
   input wire logic i_out_chain_data_out_i,
   output logic o_out_chain_data_out_o,
   output logic o_out_chain_data_out_oe,
   input wire logic i_in_chain_data_out_i,
   output logic o_in_chain_data_out_o,
   output logic o_in_chain_data_out_oe,
   output hso_pkg::hso_slot_s [hso_pkg::HSO_NSLOT-1:0] o_slot,
   output logic o_pins_tristate,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq
);
   logic [hso_pkg::HSO_SY_W-1:0] sy_in;
   logic [hso_pkg::HSO_SY_W-1:0] sy1_q;
   logic [hso_pkg::HSO_SY_W-1:0] sy2_q;
   logic [hso_pkg::HSO_SY_W-1:0] sy3_q;
   logic sh_rise;
   logic ctl_rise;
   logic rlc_rise;
   logic pg_rise;
   logic pg_fall;
   logic [hso_pkg::HSO_SR_W-1:0] sr_q;
   hso_pkg::hso_mode_e mode_q;
   logic mlo_q;
   logic mhi_q;
   hso_pkg::hso_slot_s [hso_pkg::HSO_NSLOT-1:0] hold_q;
   logic [hso_pkg::HSO_NSLOT-1:0] fault_raw_n;
   logic [hso_pkg::HSO_NSLOT-1:0] fault_s_n;
   logic runtime_test;
   logic chain_in_q;
   logic [hso_pkg::HSO_NAND_N-1:0] nand_t;
   logic ack_q;
   logic req;
   logic rd_clr;
   logic [31:0] rdata_q;
   logic [hso_pkg::HSO_EV_W-1:0] stat_q;
   logic [hso_pkg::HSO_EV_W-1:0] mask_q;
   logic [hso_pkg::HSO_EV_W-1:0] ev;
   logic [31:0] state_word;

   // Every off-domain level except the fault override and NAND tree pins passes two flops; the third flop only feeds edge detection
   assign sy_in = {i_in_chain_data_in, i_pwr_fault_n & i_aux_fault_n, i_in_chain_data_out_i,
                   i_out_chain_data_out_i, i_test, i_power_good, i_out_chain_data_in,
                   i_slot_reset_latch_clock, i_control_latch_clock, i_out_shift_clock};

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
         sy3_q <= '0;
      end else begin
         sy1_q <= sy_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end

   assign sh_rise = sy2_q[hso_pkg::HSO_SY_SHIFT] & ~sy3_q[hso_pkg::HSO_SY_SHIFT];
   assign ctl_rise = sy2_q[hso_pkg::HSO_SY_CTL] & ~sy3_q[hso_pkg::HSO_SY_CTL];
   assign rlc_rise = sy2_q[hso_pkg::HSO_SY_RLC] & ~sy3_q[hso_pkg::HSO_SY_RLC];
   assign pg_rise = sy2_q[hso_pkg::HSO_SY_PG] & ~sy3_q[hso_pkg::HSO_SY_PG];
   assign pg_fall = ~sy2_q[hso_pkg::HSO_SY_PG] & sy3_q[hso_pkg::HSO_SY_PG];
   assign fault_s_n = sy2_q[hso_pkg::HSO_SY_FLT +: hso_pkg::HSO_NSLOT];

   // New bit enters at the top; the oldest bit leaves at the bottom toward downstream
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sr_q <= '0;
      end else if (sh_rise) begin
         sr_q <= {sy2_q[hso_pkg::HSO_SY_DIN], sr_q[hso_pkg::HSO_SR_W-1:1]};
      end
   end

   // Mode is decided once per power-good rise from the pin levels seen at that edge
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_q <= hso_pkg::HSO_WAIT;
         mlo_q <= 1'b0;
         mhi_q <= 1'b0;
      end else if (pg_fall) begin
         mode_q <= hso_pkg::HSO_WAIT;
      end else if (pg_rise && mode_q == hso_pkg::HSO_WAIT) begin
         mlo_q <= sy2_q[hso_pkg::HSO_SY_MLO];
         mhi_q <= sy2_q[hso_pkg::HSO_SY_MHI];
         case ({sy2_q[hso_pkg::HSO_SY_TEST], sy2_q[hso_pkg::HSO_SY_MHI],
                sy2_q[hso_pkg::HSO_SY_MLO]})
            3'h3: mode_q <= hso_pkg::HSO_OPER;
            3'h4: mode_q <= hso_pkg::HSO_NAND;
            3'h5: mode_q <= hso_pkg::HSO_TRI;
            default: mode_q <= hso_pkg::HSO_RSVD;
         endcase
      end
   end

   // Holding registers: init at power-good, otherwise change only on a latch edge
   generate
      for (genvar i = 0; i < hso_pkg::HSO_NSLOT; i++) begin : g_slot
         localparam int BASE = (i == 0) ? hso_pkg::HSO_A_BASE : hso_pkg::HSO_B_BASE;
         logic [hso_pkg::HSO_SLOT_W-1:0] byte_v;
         assign byte_v = sr_q[BASE +: hso_pkg::HSO_SLOT_W];

         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               hold_q[i] <= hso_pkg::HSO_SLOT_INIT;
            end else if (pg_rise) begin
               hold_q[i] <= hso_pkg::HSO_SLOT_INIT;
            end else if (mode_q == hso_pkg::HSO_OPER) begin
               if (ctl_rise) begin
                  hold_q[i].pwr_en <= byte_v[hso_pkg::HSO_B_PWR];
                  hold_q[i].clk_en_n <= ~byte_v[hso_pkg::HSO_B_CLK];
                  hold_q[i].bus_en_n <= ~byte_v[hso_pkg::HSO_B_BUS];
                  hold_q[i].pled <= byte_v[hso_pkg::HSO_B_PLED];
                  hold_q[i].aled <= byte_v[hso_pkg::HSO_B_ALED];
               end
               if (rlc_rise) begin
                  hold_q[i].reset_n <= byte_v[hso_pkg::HSO_B_RST];
               end
            end
         end

         // Fault path is combinational from the pins so it acts with no clock at all
         assign fault_raw_n[i] = i_pwr_fault_n[i] & i_aux_fault_n[i];
         always_comb begin
            o_slot[i] = hold_q[i];
            if (!fault_raw_n[i]) begin
               o_slot[i].reset_n = 1'b0;
               o_slot[i].clk_en_n = 1'b1;
               o_slot[i].bus_en_n = 1'b1;
            end
            if (runtime_test) begin
               o_slot[i].pled = hold_q[i].pwr_en;
               o_slot[i].aled = ~fault_s_n[i];
            end
         end
      end
   endgenerate

   assign runtime_test = (mode_q == hso_pkg::HSO_OPER) & sy2_q[hso_pkg::HSO_SY_TEST];

   // NAND chain in tester order; first stage sees a constant high
   assign nand_t[0] = ~i_nand_tree_pins[0];
   generate
      for (genvar k = 1; k < hso_pkg::HSO_NAND_N; k++) begin : g_nand
         assign nand_t[k] = ~(i_nand_tree_pins[k] & nand_t[k-1]);
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         chain_in_q <= 1'b0;
      end else begin
         chain_in_q <= sy2_q[hso_pkg::HSO_SY_CIN];
      end
   end

   // Chain pins float until the mode is known, so mode straps can be read at power-good
   assign o_out_chain_data_out_o = sr_q[0];
   assign o_out_chain_data_out_oe = (mode_q == hso_pkg::HSO_OPER);
   assign o_in_chain_data_out_o = (mode_q == hso_pkg::HSO_NAND) ? nand_t[hso_pkg::HSO_NAND_N-1]
                                                               : chain_in_q;
   assign o_in_chain_data_out_oe = (mode_q == hso_pkg::HSO_OPER) ||
                                   (mode_q == hso_pkg::HSO_NAND);
   assign o_pins_tristate = (mode_q == hso_pkg::HSO_NAND) || (mode_q == hso_pkg::HSO_TRI);

   // Register slave: every access takes one wait cycle, answer at the second edge
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign rd_clr = i_avs_read & ack_q & (i_avs_address == hso_pkg::HSO_REG_IRQ_STAT);

   assign state_word = {{(32 - hso_pkg::HSO_ST_SLB - 6){1'b0}}, hold_q[1],
                        2'b00, hold_q[0], mhi_q, mlo_q, runtime_test, mode_q};

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_q <= '0;
      end else if (i_avs_read && !ack_q) begin
         case (i_avs_address)
            hso_pkg::HSO_REG_STATE: rdata_q <= state_word;
            hso_pkg::HSO_REG_IRQ_STAT: rdata_q <= {27'h000_0000, stat_q};
            hso_pkg::HSO_REG_IRQ_MASK: rdata_q <= {27'h000_0000, mask_q};
            hso_pkg::HSO_REG_SHIFT: rdata_q <= {16'h0000, sr_q};
            default: rdata_q <= '0;
         endcase
      end
   end
   assign o_avs_readdata = rdata_q;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mask_q <= hso_pkg::HSO_MASK_RST;
      end else if (i_avs_write && ack_q && i_avs_address == hso_pkg::HSO_REG_IRQ_MASK) begin
         mask_q <= i_avs_writedata[hso_pkg::HSO_EV_W-1:0];
      end
   end

   // A new event in the clearing cycle survives the read-clear
   assign ev = {pg_rise,
                ~fault_s_n[1] & sy3_q[hso_pkg::HSO_SY_FLT + 1],
                ~fault_s_n[0] & sy3_q[hso_pkg::HSO_SY_FLT],
                rlc_rise & (mode_q == hso_pkg::HSO_OPER),
                ctl_rise & (mode_q == hso_pkg::HSO_OPER)};

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stat_q <= '0;
      end else begin
         stat_q <= (rd_clr ? '0 : stat_q) | ev;
      end
   end
   assign o_irq = |(stat_q & mask_q);

   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_pg_oper;
      pg_rise && mode_q == hso_pkg::HSO_WAIT && !sy2_q[hso_pkg::HSO_SY_TEST]
         && sy2_q[hso_pkg::HSO_SY_MHI] && sy2_q[hso_pkg::HSO_SY_MLO];
   endsequence
   sequence s_pg_nand;
      pg_rise && mode_q == hso_pkg::HSO_WAIT && sy2_q[hso_pkg::HSO_SY_TEST]
         && !sy2_q[hso_pkg::HSO_SY_MHI] && !sy2_q[hso_pkg::HSO_SY_MLO];
   endsequence

   shift_entry_a: assert property (sh_rise |=> sr_q[hso_pkg::HSO_SR_W-1] ==
      $past(sy2_q[hso_pkg::HSO_SY_DIN]) && sr_q[hso_pkg::HSO_SR_W-2:0] ==
      $past(sr_q[hso_pkg::HSO_SR_W-1:1])) else $error("shift register did not shift");
   chain_out_a: assert property (o_out_chain_data_out_oe && sh_rise |=>
      o_out_chain_data_out_o == $past(sr_q[1])) else $error("chain output not shift tail");
   ctl_latch_a: assert property (ctl_rise && !pg_rise && mode_q == hso_pkg::HSO_OPER |=>
      hold_q[0].pwr_en == $past(sr_q[hso_pkg::HSO_A_BASE + hso_pkg::HSO_B_PWR]) &&
      hold_q[1].bus_en_n == !$past(sr_q[hso_pkg::HSO_B_BASE + hso_pkg::HSO_B_BUS]))
      else $error("control latch did not copy");
   reset_hold_a: assert property (!rlc_rise && !pg_rise |=>
      hold_q[0].reset_n == $past(hold_q[0].reset_n)) else $error("reset changed without latch");
   fault_force_a: assert property (!fault_raw_n[0] |-> !o_slot[0].reset_n &&
      o_slot[0].clk_en_n && o_slot[0].bus_en_n) else $error("fault override missing");
   pg_init_a: assert property (pg_rise |=> hold_q[1].pled && hold_q[1].aled &&
      hold_q[1].clk_en_n && !hold_q[1].reset_n) else $error("power-good init wrong");
   oper_entry_a: assert property (s_pg_oper |=> mode_q == hso_pkg::HSO_OPER [*2])
      else $error("operational mode not entered");
   nand_entry_a: assert property (s_pg_nand ##1 !pg_fall |=>
      mode_q == hso_pkg::HSO_NAND && o_pins_tristate) else $error("NAND mode not entered");
   nand_drive_a: assert property (mode_q == hso_pkg::HSO_NAND |-> o_in_chain_data_out_oe &&
      !o_out_chain_data_out_oe && o_in_chain_data_out_o == nand_t[hso_pkg::HSO_NAND_N-1])
      else $error("NAND result not driven");
   runtime_led_a: assert property (runtime_test && fault_raw_n[1] |->
      o_slot[1].pled == hold_q[1].pwr_en) else $error("run-time LED mirror wrong");
endmodule

// File: testbench/hso_ctrl_model.sv
// Model of the remote hot-plug controller that drives the output chain pins.
// Assumes i_clk is the core clock; one link half period is five of its cycles.
`timescale 1ns/1ps
module hso_ctrl_model (
   input wire logic i_clk,
   input wire logic i_chain_out,
   output logic o_shift_clock = 1'b0,
   output logic o_data = 1'b0,
   output logic o_ctl_latch = 1'b0,
   output logic o_rst_latch = 1'b0,
   output logic [31:0] o_passed = 32'h0
);
   task automatic half();
      repeat (5) @(posedge i_clk);
   endtask
   // Bit 0 leaves first, so the nearest slot's byte is shifted last
   task automatic send_frame(input logic [47:0] frame);
      @(posedge i_clk);
      for (int k = 0; k < 48; k++) begin
         o_data <= frame[k];
         half();
         if (k >= 16) o_passed[k-16] <= i_chain_out;
         o_shift_clock <= 1'b1;
         half();
         o_shift_clock <= 1'b0;
      end
      half();
      // Released data line shows the inverse of its last bit, never a stale level
      o_data <= ~frame[47];
   endtask
   // Separate latch strobes let the reset release be timed on its own
   task automatic pulse(input logic rst);
      @(posedge i_clk);
      if (rst) o_rst_latch <= 1'b1;
      else o_ctl_latch <= 1'b1;
      half();
      o_rst_latch <= 1'b0;
      o_ctl_latch <= 1'b0;
      half();
   endtask
endmodule

// File: testbench/hso_out_ctrl_tb.sv
// Self-checking bench for the two-slot serial output control block.
// Assumes the controller model drives the chain; strap pins are resolved here.
`timescale 1ns/1ps
module hso_out_ctrl_tb;
   localparam logic [47:0] FR = 48'hdba4_5a3c_960f;
   localparam logic [7:0] MD [3] = '{8'ha8, 8'hd0, 8'h30};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pg = 1'b0;
   logic tst = 1'b0;
   logic s_hi = 1'b1;
   logic s_lo = 1'b1;
   logic [1:0] pf_n = 2'h3;
   logic [1:0] af_n = 2'h3;
   logic [32:0] nand_pins = '1;
   logic [4:0] addr = 5'h00;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] avs_rdata, passed;
   logic sclk, sdat, clat, rlat, dout_o, dout_oe, din_o, din_oe, tri_s, wreq, irq;
   hso_pkg::hso_slot_s [1:0] slot;
   int n_errors = 0;
   int checked = 0;
   wire dout_pin = dout_oe ? dout_o : s_hi;
   wire din_pin = din_oe ? din_o : s_lo;
   always #4 clk = ~clk;
   hso_ctrl_model i_ctrl (.i_clk(clk), .i_chain_out(dout_pin), .o_shift_clock(sclk),
      .o_data(sdat), .o_ctl_latch(clat), .o_rst_latch(rlat), .o_passed(passed));
   hso_out_ctrl i_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_out_shift_clock(sclk),
      .i_control_latch_clock(clat), .i_slot_reset_latch_clock(rlat),
      .i_out_chain_data_in(sdat), .i_power_good(pg), .i_test(tst), .i_pwr_fault_n(pf_n),
      .i_aux_fault_n(af_n), .i_in_chain_data_in(1'b0), .i_nand_tree_pins(nand_pins),
      .i_out_chain_data_out_i(dout_pin), .o_out_chain_data_out_o(dout_o),
      .o_out_chain_data_out_oe(dout_oe), .i_in_chain_data_out_i(din_pin),
      .o_in_chain_data_out_o(din_o), .o_in_chain_data_out_oe(din_oe), .o_slot(slot),
      .o_pins_tristate(tri_s), .i_avs_address(addr), .i_avs_read(rd_s),
      .i_avs_write(wr_s), .i_avs_writedata(wdata), .o_avs_readdata(avs_rdata),
      .o_avs_waitrequest(wreq), .o_irq(irq));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= w;
      rd_s <= ~w;
      // Waitrequest and read data are taken at the very edge that completes the access
      do @(posedge clk); while (wreq !== 1'b0);
      q = avs_rdata;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask
   task automatic pg_up(input logic t, input logic h, input logic l);
      @(posedge clk);
      pg <= 1'b0;
      tst <= t;
      s_hi <= h;
      s_lo <= l;
      cyc(8);
      @(posedge clk);
      pg <= 1'b1;
      cyc(10);
   endtask
   // Expected pin levels of one slot from its control byte and reset level
   function automatic logic [5:0] exs(input logic [7:0] b, input logic r);
      return {b[0], ~b[1], ~b[2], r, b[4], b[5]};
   endfunction
   task automatic t_reset();
      logic [31:0] q;
      chk("irq", 32'h0, irq);
      bus(1'b0, hso_pkg::HSO_REG_IRQ_MASK, 32'h0, q);
      chk("mask", 32'(hso_pkg::HSO_MASK_RST), q);
      bus(1'b0, 5'h1c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      chk("dout_oe", 32'h0, dout_oe);
   endtask
   task automatic t_power_on();
      logic [31:0] q;
      pg_up(1'b0, 1'b1, 1'b1);
      bus(1'b0, hso_pkg::HSO_REG_STATE, 32'h0, q);
      chk("state", 32'h0000_00c2, {24'h0, q[7:0]});
      for (int s = 0; s < 2; s++) chk("init", 32'h0000_001b, slot[s][4:0]);
   endtask
   task automatic t_frame();
      logic [31:0] q;
      i_ctrl.send_frame(FR);
      cyc(4);
      bus(1'b0, hso_pkg::HSO_REG_SHIFT, 32'h0, q);
      chk("shift", {16'h0, FR[47:32]}, {16'h0, q[15:0]});
      chk("passed", FR[31:0], passed);
      i_ctrl.pulse(1'b0);
      cyc(6);
      chk("slot_a", exs(FR[47:40], 1'b0), slot[0]);
      chk("slot_b", exs(FR[39:32], 1'b0), slot[1]);
      i_ctrl.pulse(1'b1);
      cyc(6);
      chk("rst_a", exs(FR[47:40], FR[43]), slot[0]);
      chk("rst_b", exs(FR[39:32], FR[35]), slot[1]);
   endtask
   task automatic t_fault();
      logic [31:0] q;
      int n;
      bus(1'b0, hso_pkg::HSO_REG_IRQ_STAT, 32'h0, q);
      bus(1'b1, hso_pkg::HSO_REG_IRQ_MASK, 32'h0000_0004, q);
      bus(1'b0, hso_pkg::HSO_REG_IRQ_MASK, 32'h0, q);
      chk("mask_rw", 32'h0000_0004, q);
      @(posedge clk);
      pf_n <= 2'h2;
      @(negedge clk);
      chk("fault_a", 32'h0000_003a, slot[0]);
      chk("fault_b", exs(FR[39:32], 1'b0), slot[1]);
      // Auxiliary fault alone must force the same override on slot B
      @(posedge clk);
      af_n <= 2'h1;
      @(negedge clk);
      chk("aux_fault_b", 32'h0000_0019, slot[1]);
      @(posedge clk);
      af_n <= 2'h3;
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("irq_on", 32'h1, irq);
      bus(1'b1, hso_pkg::HSO_REG_IRQ_MASK, 32'h0, q);
      cyc(1);
      chk("irq_masked", 32'h0, irq);
      bus(1'b1, hso_pkg::HSO_REG_IRQ_MASK, 32'h0000_0004, q);
      cyc(1);
      chk("irq_unmasked", 32'h1, irq);
      bus(1'b0, hso_pkg::HSO_REG_IRQ_STAT, 32'h0, q);
      chk("stat_a", 32'h1, q[2]);
      cyc(1);
      chk("irq_clear", 32'h0, irq);
   endtask
   task automatic t_runtime();
      logic [31:0] q;
      @(posedge clk);
      tst <= 1'b1;
      cyc(8);
      chk("led_a", 32'h3, slot[0][1:0]);
      chk("led_b", 32'h0, slot[1][1:0]);
      bus(1'b0, hso_pkg::HSO_REG_STATE, 32'h0, q);
      chk("rtt", 32'h1, q[5]);
      @(posedge clk);
      pf_n <= 2'h3;
      cyc(8);
      chk("led_a_ok", 32'h2, slot[0][1:0]);
      @(posedge clk);
      tst <= 1'b0;
      cyc(8);
      chk("hold_a", exs(FR[47:40], FR[43]), slot[0]);
      chk("hold_b", exs(FR[39:32], FR[35]), slot[1]);
   endtask
   task automatic t_nand();
      logic [31:0] q;
      pg_up(1'b1, 1'b0, 1'b0);
      bus(1'b0, hso_pkg::HSO_REG_STATE, 32'h0, q);
      chk("mode_nand", 32'h4, q[4:0]);
      chk("tristate", 32'h1, tri_s);
      chk("nand_oe", 32'h1, din_oe);
      chk("out_chain_data_out_oe", 32'h0, dout_oe);
      // Test pin comes last and goes high then low; every other input low then high
      for (int k = 0; k < 33; k++) begin
         @(posedge clk);
         nand_pins[k] <= (k == 32);
         cyc(2);
         chk("nand_first", (k == 32) ? 32'h0 : ((k % 2 == 0) ? 32'h1 : 32'h0), din_o);
         @(posedge clk);
         nand_pins[k] <= (k != 32);
         cyc(2);
         chk("nand_second", (k == 32) ? 32'h1 : 32'h0, din_o);
      end
   endtask
   task automatic t_modes();
      logic [31:0] q;
      for (int i = 0; i < 3; i++) begin
         pg_up(MD[i][7], MD[i][6], MD[i][5]);
         bus(1'b0, hso_pkg::HSO_REG_STATE, 32'h0, q);
         chk("mode", {27'h0, MD[i][4:0]}, {27'h0, q[4:0]});
         if (i == 0) chk("tri_pins", 32'h2, {tri_s, din_oe});
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_power_on();
      t_frame();
      t_fault();
      t_runtime();
      t_nand();
      t_modes();
      wrap_up();
   end
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule
